// ==== shared/ref_clock_pkg.sv ====
// What this block does
// [R01] Fixed 5 ms wait before firmware runs.
// [R02] Extension by startup delay, 5 to 31 ms.
// [R03] Source within 250 ppm by 7 ms.
// [R04] Source within 20 ppm by 11 ms.
// [R05] Request driven on GPIO only when enabled.
// [R06] Reference frequency setting counts in 1 kHz.
// [R07] Reference frequency defaults to 26000.
// [R08] Accept cellular list plus 250 kHz multiples.
// [R09] Source should be 250 kHz multiple.
// [R10] Grounded drive pin selects external clock mode.
// [R11] All clocks derive from reference input.
// [R12] Hold firmware until whole delay has elapsed.
package ref_clock_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000; // Bus clock rate in hertz.
    localparam int unsigned FIXED_DELAY_MS = 5; // Fixed hardware wait in ms.
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000; // Cycles per millisecond.
    localparam int unsigned ACCURACY_250_MS = 7; // Time of coarse accuracy in ms.
    localparam int unsigned ACCURACY_20_MS = 11; // Time of radio accuracy in ms.
    localparam logic [4:0] DELAY_MIN = 5'h05; // Least extension setting.
    localparam logic [4:0] DELAY_MAX = 5'h1f; // Largest extension setting.

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h000; // Control register.
    localparam logic [11:0] FREQ_OFFSET = 12'h004; // Reference frequency.
    localparam logic [11:0] STATUS_OFFSET = 12'h008; // Status register.
    localparam int unsigned CTRL_START_BIT = 0; // Writing one starts a request.
    localparam int unsigned CTRL_OE_BIT = 1; // Request output enable.
    localparam int unsigned CTRL_DELAY_LSB = 8; // Extension field, five bits.
    localparam logic [15:0] FREQ_RESET = 16'h6590; // 26000 kHz.
    localparam logic [15:0] FREQ_STEP = 16'h00fa; // 250 kHz step.
    localparam logic [4:0] DELAY_RESET = 5'h00; // No extension after reset.

    // Cellular reference frequencies in kHz.
    localparam logic [15:0] CELL_FREQ [10] = '{16'h1e00, 16'h3840, 16'h3c00, 16'h3f48,
        16'h41a0, 16'h4b00, 16'h4bf0, 16'h4ce0, 16'h4d58, 16'h9600};

    // Sequencer states.
    typedef enum logic [1:0] {IDLE, FIXED_WAIT, EXT_WAIT, RUN} seq_t;

    // Configuration carried to the sequencer.
    typedef struct packed {
        logic start;
        logic [4:0] delay_ms;
    } seq_cfg_t;

    // Status returned by the sequencer.
    typedef struct packed {
        logic clk_req;
        logic fw_run;
        logic acc_250;
        logic acc_20;
    } seq_stat_t;

endpackage

// ==== src/ms_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Millisecond tick generator; runs while enabled, clears otherwise.
module ms_timer #(
    parameter int unsigned MS_CYCLES = ref_clock_pkg::MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic tick
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } tmr_t;
    tmr_t q, d;

    // Count to one millisecond then pulse.
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = 16'h0000;
        end else if (q.cnt == 16'(MS_CYCLES - 1)) begin
            d.cnt = 16'h0000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    // Register the state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule // ms_timer
`default_nettype wire

// ==== src/ref_clock_request_startup.sv ====
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Reference clock request and start-up sequencer with an APB register file.
module ref_clock_request_startup #(
    // Cycles per millisecond; a bench may shorten it to keep runs small.
    parameter int unsigned MS_CYCLES = ref_clock_pkg::MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic crystal_drive_output_in, // Level seen on the drive pin.
    output logic crystal_drive_output_out,
    output logic crystal_drive_output_oe,
    output logic crystal_driver_enable, // Turns the analogue driver on.
    output logic ext_clock_mode,
    output logic clk_req, // Internal request level.
    output logic clk_req_gpio_out,
    output logic clk_req_gpio_oe,
    output logic fw_run, // Firmware may execute.
    output logic [15:0] ref_freq_khz,
    output logic ref_freq_supported
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ref_clock_pkg::seq_t st;
        logic [4:0] ms;      // Milliseconds elapsed in current phase.
        logic [4:0] total;   // Milliseconds since request; stops counting in RUN.
        logic oe;
        logic [4:0] delay;
        logic [15:0] freq;
        logic [31:0] rdata;
        logic start;
        logic pin_s1;
        logic pin_s2;
        logic ext;
        logic strap_done;
        logic [1:0] strap_cnt; // Edges spent filling the pin synchroniser.
        logic acc_250;
        logic acc_20;
    } state_t;
    state_t q, d;

    logic tick; // One pulse per millisecond during the fixed and extension waits.
    logic access; // Access phase of an APB transfer.
    logic mapped;

    ms_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(q.st == ref_clock_pkg::FIXED_WAIT || q.st == ref_clock_pkg::EXT_WAIT),
        .tick(tick)
    );

    // Frequency check: list member or whole 250 kHz multiple.
    function automatic logic freq_ok(input logic [15:0] f);
        logic ok;
        ok = ((f % ref_clock_pkg::FREQ_STEP) == 16'h0000) && (f != 16'h0000);
        for (int i = 0; i < 10; i++) begin
            if (f == ref_clock_pkg::CELL_FREQ[i]) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    assign access = psel && penable;
    assign mapped = (paddr == ref_clock_pkg::CTRL_OFFSET) ||
        (paddr == ref_clock_pkg::FREQ_OFFSET) || (paddr == ref_clock_pkg::STATUS_OFFSET);

    // Next-state logic for bus, strap and sequencer.
    always_comb begin
        d = q;
        d.start = 1'b0;
        d.pin_s1 = crystal_drive_output_in;
        d.pin_s2 = q.pin_s1;
        // Catch the pin strap once after reset; a grounded pin means external clock.
        // The capture waits until both synchroniser stages hold the real pin level,
        // otherwise the reset value of the stages would be taken for the strap.
        if (!q.strap_done) begin
            if (q.strap_cnt == 2'h2) begin
                d.ext = !q.pin_s2; // R10
                d.strap_done = 1'b1;
            end else begin
                d.strap_cnt = q.strap_cnt + 2'h1;
            end
        end
        // Register writes take effect in the access phase.
        if (access && pwrite) begin
            if (paddr == ref_clock_pkg::CTRL_OFFSET) begin
                d.start = pwdata[ref_clock_pkg::CTRL_START_BIT];
                d.oe = pwdata[ref_clock_pkg::CTRL_OE_BIT];
                // Out-of-range extensions are ignored so a bad value cannot shorten it.
                if (pwdata[ref_clock_pkg::CTRL_DELAY_LSB +: 5] >= ref_clock_pkg::DELAY_MIN ||
                    pwdata[ref_clock_pkg::CTRL_DELAY_LSB +: 5] == 5'h00) begin
                    d.delay = pwdata[ref_clock_pkg::CTRL_DELAY_LSB +: 5]; // R02
                end
            end else if (paddr == ref_clock_pkg::FREQ_OFFSET) begin
                d.freq = pwdata[15:0]; // R06
            end
        end
        // Read data is captured in the setup phase and held for the access.
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ref_clock_pkg::CTRL_OFFSET: begin
                    d.rdata = {19'h00000, q.delay, 6'h00, q.oe, 1'b0};
                end
                ref_clock_pkg::FREQ_OFFSET: begin
                    d.rdata = {16'h0000, q.freq};
                end
                ref_clock_pkg::STATUS_OFFSET: begin
                    d.rdata = {18'h00000, freq_ok(q.freq), q.ext, q.acc_20, q.acc_250,
                        3'h0, q.total, q.st == ref_clock_pkg::RUN,
                        q.st != ref_clock_pkg::IDLE};
                end
                default: begin
                    d.rdata = 32'h00000000;
                end
            endcase
        end
        // Sequencer: request, fixed wait, optional extension, then run.
        if (tick && q.total != 5'h1f) begin
            d.total = q.total + 5'h01;
        end
        d.acc_250 = (q.total >= 5'(ref_clock_pkg::ACCURACY_250_MS)); // R03
        d.acc_20 = (q.total >= 5'(ref_clock_pkg::ACCURACY_20_MS)); // R04
        case (q.st)
            ref_clock_pkg::IDLE: begin
                d.ms = 5'h00;
                d.total = 5'h00;
                if (q.start) begin
                    d.st = ref_clock_pkg::FIXED_WAIT;
                end
            end
            ref_clock_pkg::FIXED_WAIT: begin
                if (tick) begin
                    d.ms = q.ms + 5'h01;
                    if (q.ms == 5'(ref_clock_pkg::FIXED_DELAY_MS - 1)) begin // R01
                        d.ms = 5'h00;
                        d.st = (q.delay == 5'h00) ? ref_clock_pkg::RUN :
                            ref_clock_pkg::EXT_WAIT; // R12
                    end
                end
            end
            ref_clock_pkg::EXT_WAIT: begin
                if (tick) begin
                    d.ms = q.ms + 5'h01;
                    if (q.ms == q.delay - 5'h01) begin // R02
                        d.st = ref_clock_pkg::RUN; // R12
                    end
                end
            end
            ref_clock_pkg::RUN: begin
                d.ms = 5'h00;
            end
            default: begin
                d.st = ref_clock_pkg::IDLE;
            end
        endcase
    end

    // Register the whole state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.freq <= ref_clock_pkg::FREQ_RESET; // R07
            q.delay <= ref_clock_pkg::DELAY_RESET;
            q.st <= ref_clock_pkg::IDLE;
            q.pin_s1 <= 1'b1;
            q.pin_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = q.rdata;
    assign clk_req = q.st != ref_clock_pkg::IDLE; // R12
    assign fw_run = q.st == ref_clock_pkg::RUN; // R12
    assign clk_req_gpio_out = clk_req;
    assign clk_req_gpio_oe = q.oe; // R05
    assign ext_clock_mode = q.ext;
    // The drive pin is never driven low in external mode, only released.
    assign crystal_drive_output_out = 1'b0;
    assign crystal_drive_output_oe = 1'b0; // R10
    assign crystal_driver_enable = q.strap_done && !q.ext; // R10
    assign ref_freq_khz = q.freq; // R11
    assign ref_freq_supported = freq_ok(q.freq); // R08
endmodule // ref_clock_request_startup
`default_nettype wire

// ==== verif/ref_clock_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// Start-up checker.
// ----------
module ref_clock_asserts #(
    parameter int unsigned MS_CYCLES = ref_clock_pkg::MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic crystal_drive_output_oe,
    input wire logic crystal_driver_enable,
    input wire logic ext_clock_mode,
    input wire logic clk_req,
    input wire logic clk_req_gpio_out,
    input wire logic clk_req_gpio_oe,
    input wire logic fw_run,
    input wire logic [15:0] ref_freq_khz
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ctrl; // Write access to the control word.
    logic wr_freq; // Write access to the frequency word.
    logic [31:0] cnt_q; // Request cycles before firmware runs.
    logic [31:0] lim_q; // Wait expected for the last start.
    assign wr_ctrl = psel && penable && pwrite && paddr == 12'h000;
    assign wr_freq = psel && penable && pwrite && paddr == 12'h004;
    // Settings of 1 to 4 are counted here as adding nothing to the wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h0;
            lim_q <= 32'h0;
        end else begin
            cnt_q <= clk_req && !fw_run ? cnt_q + 32'h1 : (clk_req ? cnt_q : 32'h0);
            if (wr_ctrl && pwdata[0] && !clk_req) begin
                lim_q <= (32'h5 + (pwdata[12:8] >= 5'h05 ? 32'(pwdata[12:8]) : 32'h0))
                    * MS_CYCLES;
            end
        end
    end
    req_hold_a: assert property (clk_req |=> clk_req)
        else $error("request dropped");
    run_needs_req_a: assert property (fw_run |-> clk_req)
        else $error("firmware runs without request");
    wait_len_a: assert property ($rose(fw_run) |-> cnt_q + 2 >= lim_q && cnt_q <= lim_q + 8)
        else $error("start-up wait has wrong length");
    start_req_a: assert property (wr_ctrl && pwdata[0] && !clk_req |-> ##[1:4] clk_req)
        else $error("request not raised");
    gpio_oe_a: assert property (wr_ctrl |=> clk_req_gpio_oe == $past(pwdata[1]))
        else $error("output enable wrong");
    gpio_level_a: assert property (clk_req_gpio_oe |-> clk_req_gpio_out == clk_req)
        else $error("pin level wrong");
    pin_free_a: assert property (!crystal_drive_output_oe)
        else $error("drive pin driven");
    ext_mode_a: assert property (ext_clock_mode |-> !crystal_driver_enable)
        else $error("driver on in external mode");
    freq_dflt_a: assert property ($rose(presetn) |-> ref_freq_khz == 16'h6590)
        else $error("frequency default wrong");
    freq_wr_a: assert property (wr_freq |=> ref_freq_khz == $past(pwdata[15:0]))
        else $error("frequency not written");
endmodule // ref_clock_asserts
`default_nettype wire

// ==== verif/ref_clock_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// Board reference source and drive pin.
// ----------
module ref_clock_source_model #(
    parameter int unsigned MS_CYCLES = ref_clock_pkg::MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_req,
    input wire logic tie_low, // Board grounds the drive pin.
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level,
    output logic [15:0] ppm_err
);
    logic [31:0] t_q; // Cycles since the request rose.
    // An undriven pin on a crystal board is not low; only the tie reads low.
    assign pin_level = pin_oe ? pin_out : !tie_low;
    // Accuracy comes as late as allowed, never earlier, to stress the wait.
    assign ppm_err = t_q >= 11 * MS_CYCLES ? 16'h0014 :
        (t_q >= 7 * MS_CYCLES ? 16'h00fa : 16'hffff);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) t_q <= 32'h0;
        else if (!clk_req) t_q <= 32'h0;
        else t_q <= t_q + 32'h1;
    end
endmodule // ref_clock_source_model
`default_nettype wire

// ==== verif/tb_ref_clock_request_startup.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_ref_clock_request_startup;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tie_low, err;
    logic crystal_drive_output_in, crystal_drive_output_out, crystal_drive_output_oe;
    logic crystal_driver_enable, ext_clock_mode, clk_req, clk_req_gpio_out;
    logic clk_req_gpio_oe, fw_run, ref_freq_supported;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, lfsr;
    logic [15:0] ref_freq_khz, ppm, v;
    int error_cnt, n_tests, i, n;
    // A shortened millisecond keeps the long start-up waits within the run budget.
    localparam int MS = 20;
    ref_clock_request_startup #(.MS_CYCLES(MS)) i_ref_clock_request_startup (.pclk, .presetn,
        .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .crystal_drive_output_in,
        .crystal_drive_output_out, .crystal_drive_output_oe, .crystal_driver_enable,
        .ext_clock_mode, .clk_req, .clk_req_gpio_out, .clk_req_gpio_oe, .fw_run,
        .ref_freq_khz, .ref_freq_supported);
    ref_clock_source_model #(.MS_CYCLES(MS)) i_ref_clock_source_model (.pclk, .presetn,
        .clk_req, .tie_low,
        .pin_out(crystal_drive_output_out), .pin_oe(crystal_drive_output_oe),
        .pin_level(crystal_drive_output_in), .ppm_err(ppm));
    always #25 pclk = ~pclk;
    // Next value of the stimulus shift register.
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected support: cellular list or nonzero 250 kHz multiple.
    function automatic logic freq_ok(input logic [15:0] f);
        freq_ok = f != 16'h0000 && f % 16'h00fa == 16'h0000;
        for (int k = 0; k < 10; k++) freq_ok |= f == ref_clock_pkg::CELL_FREQ[k];
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Errors %0d, comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One APB transfer; the edge after release is spent so the next setup is clean.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            wrap_up();
        end
        @(posedge pclk);
    endtask
    task automatic do_reset(input logic strap);
        tie_low <= strap;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, tie_low} = '0;
        {error_cnt, n_tests, lfsr} = {32'h0, 32'h0, 32'ha106};
        do_reset(1'b1);
        check({ext_clock_mode, crystal_driver_enable}, 32'h2);
        do_reset(1'b0);
        check({ext_clock_mode, crystal_driver_enable}, 32'h1);
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        check(err, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h6590);
        for (i = 0; i < 30; i++) begin
            lfsr = lfsr_next(lfsr);
            v = i < 10 ? ref_clock_pkg::CELL_FREQ[i] : (i < 20 ?
                16'((lfsr % 262) * 250 + 250) : lfsr[15:0] | 16'h0001);
            apb(1'b1, 12'h004, {16'h0000, v});
            apb(1'b0, 12'h004, 32'h0);
            check(rd, {16'h0000, v});
            check(ref_freq_supported, freq_ok(v));
        end
        apb(1'b1, 12'h000, 32'h0000_0002);
        check({clk_req, clk_req_gpio_oe, clk_req_gpio_out, fw_run}, 32'h4);
        apb(1'b1, 12'h000, 32'h0000_0503);
        for (n = 0; fw_run !== 1'b1 && n < 11 * MS; n++) @(posedge pclk);
        check(n >= 10 * MS - 10 && n <= 10 * MS + 10, 32'h1);
        check({clk_req, clk_req_gpio_out}, 32'h3);
        check(ppm, 32'h00fa);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0000_042b);
        apb(1'b1, 12'h000, 32'h0);
        check({clk_req, clk_req_gpio_oe, fw_run}, 32'h5);
        do_reset(1'b0);
        check({clk_req, fw_run, ref_freq_khz}, 32'h6590);
        wrap_up();
    end
endmodule // tb_ref_clock_request_startup
bind ref_clock_request_startup ref_clock_asserts #(.MS_CYCLES(MS_CYCLES)) i_ref_clock_asserts (
    .pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .crystal_drive_output_oe,
    .crystal_driver_enable, .ext_clock_mode, .clk_req, .clk_req_gpio_out,
    .clk_req_gpio_oe, .fw_run, .ref_freq_khz);
`default_nettype wire
